// ==== inc/scf_defs.vh ====
/*
 * constants of the slave command forwarder: command nibbles, link classes,
 * stop-cause bit positions of the completion status byte.
 * assumes it is included once per compile unit by its bare name.
 */
`ifndef SCF_DEFS_VH
`define SCF_DEFS_VH

`define SCF_NIB_START    4'h0
`define SCF_NIB_OUTPUT   4'h1
`define SCF_NIB_INPUT    4'h2

`define SCF_CLS_START    2'h0
`define SCF_CLS_OUTPUT   2'h1
`define SCF_CLS_INPUT    2'h2

`define SCF_ST_ALARM     7
`define SCF_ST_CW_LIM    6
`define SCF_ST_CCW_LIM   5
`define SCF_ST_CW_FAST   4
`define SCF_ST_CCW_FAST  3
`define SCF_ST_ORIGIN    2
`define SCF_ST_STOP_CMD  1
`define SCF_ST_NORMAL    0

`define SCF_ADDR_HI      4'h0
`define SCF_BYTE_ZERO    8'h00

`endif

// ==== rtl/scf_top.v ====
/*
 * slave command forwarder: host command/data writes are checked for a
 * slave start, output or input command and the bytes are passed through a
 * fifo to the slave link; slave answers are gathered into a reply buffer
 * that the host drains byte by byte.
 * assumes host and link ports are synchronous logic on i_clk.
 */
// What this block does
// - command nibble 0 selects start command
// - operation bytes never interpreted by block
// - start command begins polling unless its length byte is 0
// - output command starts no polling, run-end
// - synchronizing unit slaves use start commands
// - start reply: address byte, then ack
// - reply sets output flag, interrupt until read
// - run end while polling: address, status
// - status bits: alarm down to normal end
// - command nibble 2 selects input command
// - input reply: address then bytes, flag
`include "scf_defs.vh"

module scf_fifo #(
   parameter W  = 9,
   parameter D  = 16,
   parameter AW = 4
) (
   input  wire         i_clk,
   input  wire         i_rst_b,
   input  wire         i_in_valid,
   output wire         o_in_ready,
   input  wire [W-1:0] i_in_data,
   output wire         o_out_valid,
   input  wire         i_out_ready,
   output wire [W-1:0] o_out_data
);
   reg [W-1:0] mem [0:D-1];
   reg [AW:0]  wp_r;
   reg [AW:0]  rp_r;
   wire        empty = (wp_r == rp_r);
   wire        full  = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);

   assign o_in_ready  = ~full;
   assign o_out_valid = ~empty;
   assign o_out_data  = mem[rp_r[AW-1:0]];

   always @(posedge i_clk) begin
      if (i_in_valid && !full) begin
         mem[wp_r[AW-1:0]] <= i_in_data;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         wp_r <= {(AW+1){1'b0}};
         rp_r <= {(AW+1){1'b0}};
      end else begin
         if (i_in_valid && !full) begin
            wp_r <= wp_r + 1'b1;
         end
         if (i_out_ready && !empty) begin
            rp_r <= rp_r + 1'b1;
         end
      end
   end
endmodule // scf_fifo

module scf_top #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW    = 4,
   parameter RPL_DEPTH  = 16,
   parameter RPL_AW     = 4
) (
   input  wire       i_clk,
   input  wire       i_rst_b,
   input  wire       i_cmd_we,
   input  wire       i_data_we,
   input  wire [7:0] i_wdata,
   input  wire       i_data_re,
   output reg  [7:0] o_rdata,
   output wire       o_host_ready,
   output wire       o_reply_valid,
   output wire       o_output_full_flag,
   output wire       o_input_data_flag,
   output wire       o_run_end_interrupt,
   output wire       o_int_b,
   input  wire       i_completion_signal_select,
   input  wire       i_poll_stop,
   output wire       o_polling_active,
   output wire       o_link_valid,
   input  wire       i_link_ready,
   output wire [7:0] o_link_data,
   output wire       o_link_last,
   output wire [3:0] o_link_addr,
   output wire [1:0] o_link_class,
   input  wire       i_rx_valid,
   input  wire [7:0] i_rx_data,
   output wire       o_rx_ready,
   input  wire       i_done_valid,
   input  wire [3:0] i_done_addr,
   input  wire [7:0] i_done_status,
   output wire       o_done_ready,
   output wire       o_alarm_stop_flag,
   output wire       o_cw_limit_stop_flag,
   output wire       o_ccw_limit_stop_flag,
   output wire       o_cw_fast_limit_flag,
   output wire       o_ccw_fast_limit_flag,
   output wire       o_origin_stop_flag,
   output wire       o_stop_command_flag,
   output wire       o_normal_end_flag
);
   localparam [2:0] S_IDLE  = 3'd0;
   localparam [2:0] S_LEN   = 3'd1;
   localparam [2:0] S_BYTES = 3'd2;
   localparam [2:0] S_WAIT  = 3'd3;
   localparam [2:0] S_READ  = 3'd4;

   reg [2:0]        state_r;
   reg [1:0]        cls_r;
   reg [3:0]        addr_r;
   reg [7:0]        remain_r;
   reg [7:0]        expect_r;
   reg [RPL_AW:0]   wr_r;
   reg [RPL_AW:0]   rd_r;
   reg              poll_r;
   reg              ofull_r;
   reg              indata_r;
   reg              runend_r;
   reg [7:0]        status_r;
   reg [7:0]        rpl_mem [0:RPL_DEPTH-1];

   wire [3:0] cmd_nib = i_wdata[7:4];
   wire       fifo_in_ready;
   wire [8:0] fifo_out;
   wire       push     = (state_r == S_BYTES) && i_data_we && fifo_in_ready;
   wire       last_b   = (remain_r == 8'h01);
   wire       rx_take  = (state_r == S_WAIT) && i_rx_valid;
   wire       done_tk  = i_done_valid && o_done_ready;
   wire       rd_take  = (state_r == S_READ) && i_data_re;
   wire       rpl_room = (wr_r < RPL_DEPTH);

   // operation bytes are passed through blind; the host picks the class
   scf_fifo #(.W(9), .D(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
      .i_clk       (i_clk),
      .i_rst_b     (i_rst_b),
      .i_in_valid  (push),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   ({last_b, i_wdata}),
      .o_out_valid (o_link_valid),
      .i_out_ready (i_link_ready),
      .o_out_data  (fifo_out)
   );

   assign o_link_data  = fifo_out[7:0];
   assign o_link_last  = fifo_out[8];
   assign o_link_addr  = addr_r;
   assign o_link_class = cls_r;
   assign o_host_ready = (state_r == S_IDLE) || (state_r == S_LEN) ||
                         ((state_r == S_BYTES) && fifo_in_ready);
   assign o_rx_ready   = (state_r == S_WAIT);
   // run end waits for idle and yields to a host command write in the same
   // cycle, so neither a reply nor a command is lost
   assign o_done_ready = poll_r && (state_r == S_IDLE) && !i_cmd_we;
   assign o_reply_valid       = (state_r == S_READ);
   assign o_output_full_flag  = ofull_r;
   assign o_input_data_flag   = indata_r;
   assign o_run_end_interrupt = runend_r;
   assign o_int_b             = ~(ofull_r | indata_r | runend_r);
   assign o_polling_active    = poll_r;

   assign o_alarm_stop_flag     = status_r[`SCF_ST_ALARM];
   assign o_cw_limit_stop_flag  = status_r[`SCF_ST_CW_LIM];
   assign o_ccw_limit_stop_flag = status_r[`SCF_ST_CCW_LIM];
   assign o_cw_fast_limit_flag  = status_r[`SCF_ST_CW_FAST];
   assign o_ccw_fast_limit_flag = status_r[`SCF_ST_CCW_FAST];
   assign o_origin_stop_flag    = status_r[`SCF_ST_ORIGIN];
   assign o_stop_command_flag   = status_r[`SCF_ST_STOP_CMD];
   assign o_normal_end_flag     = status_r[`SCF_ST_NORMAL];

   // reply buffer: slot 0 always holds the address byte, upper nibble zero
   always @(posedge i_clk) begin
      if ((state_r == S_BYTES) && push && last_b) begin
         rpl_mem[0] <= {`SCF_ADDR_HI, addr_r};
      end else if (done_tk) begin
         rpl_mem[0] <= {`SCF_ADDR_HI, i_done_addr};
         rpl_mem[1] <= i_done_status;
      end else if (rx_take && rpl_room) begin
         rpl_mem[wr_r[RPL_AW-1:0]] <= i_rx_data;
      end
   end

   always @(posedge i_clk) begin
      if (!i_rst_b) begin
         state_r  <= S_IDLE;
         cls_r    <= `SCF_CLS_START;
         addr_r   <= 4'h0;
         remain_r <= 8'h00;
         expect_r <= 8'h00;
         wr_r     <= {(RPL_AW+1){1'b0}};
         rd_r     <= {(RPL_AW+1){1'b0}};
         poll_r   <= 1'b0;
         ofull_r  <= 1'b0;
         indata_r <= 1'b0;
         runend_r <= 1'b0;
         status_r <= `SCF_BYTE_ZERO;
         o_rdata  <= 8'h00;
      end else begin
         o_rdata <= rpl_mem[rd_r[RPL_AW-1:0]];
         if (i_poll_stop) begin
            poll_r <= 1'b0;
         end
         case (state_r)
            S_IDLE: begin
               if (done_tk) begin
                  status_r <= i_done_status;
                  wr_r     <= 5'd2;
                  rd_r     <= {(RPL_AW+1){1'b0}};
                  runend_r <= i_completion_signal_select;
                  state_r  <= S_READ;
               end else if (i_cmd_we) begin
                  addr_r <= i_wdata[3:0];
                  if (cmd_nib == `SCF_NIB_START) begin
                     cls_r   <= `SCF_CLS_START;
                     state_r <= S_LEN;
                  end else if (cmd_nib == `SCF_NIB_OUTPUT) begin
                     cls_r   <= `SCF_CLS_OUTPUT;
                     state_r <= S_LEN;
                  end else if (cmd_nib == `SCF_NIB_INPUT) begin
                     cls_r   <= `SCF_CLS_INPUT;
                     state_r <= S_LEN;
                  end
               end
            end
            S_LEN: begin
               if (i_data_we) begin
                  // input: length is the reply count; one command byte follows
                  if (cls_r == `SCF_CLS_INPUT) begin
                     expect_r <= i_wdata;
                     remain_r <= 8'h01;
                     state_r  <= S_BYTES;
                  end else begin
                     expect_r <= 8'h01;
                     remain_r <= i_wdata;
                     state_r  <= (i_wdata == 8'h00) ? S_IDLE : S_BYTES;
                  end
               end
            end
            S_BYTES: begin
               if (push) begin
                  remain_r <= remain_r - 8'h01;
                  if (last_b) begin
                     wr_r    <= 5'd1;
                     rd_r    <= {(RPL_AW+1){1'b0}};
                     state_r <= (expect_r == 8'h00) ? S_READ : S_WAIT;
                     indata_r <= (expect_r == 8'h00) && (cls_r == `SCF_CLS_INPUT);
                     if (cls_r == `SCF_CLS_START) begin
                        poll_r <= 1'b1;
                     end
                  end
               end
            end
            S_WAIT: begin
               if (rx_take) begin
                  // bytes beyond the buffer are counted but dropped
                  if (rpl_room) begin
                     wr_r <= wr_r + 1'b1;
                  end
                  expect_r <= expect_r - 8'h01;
                  if (expect_r == 8'h01) begin
                     state_r <= S_READ;
                     if (cls_r == `SCF_CLS_INPUT) begin
                        indata_r <= 1'b1;
                     end else begin
                        ofull_r <= 1'b1;
                     end
                  end
               end
            end
            S_READ: begin
               if (rd_take) begin
                  rd_r <= rd_r + 1'b1;
                  if (rd_r + 1'b1 >= wr_r) begin
                     ofull_r  <= 1'b0;
                     indata_r <= 1'b0;
                     runend_r <= 1'b0;
                     state_r  <= S_IDLE;
                  end
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule // scf_top

// ==== verif/scf_slave_model.sv ====
/* slave link model: records forwarded bytes, answers a finished start or output command with one byte, an input command with i_nrep bytes.
   assumes valid/ready transfers on rising edges of i_clk. */
module scf_slave_model (
   input  wire        i_clk,
   input  wire        i_stall,
   input  wire  [3:0] i_nrep,
   input  wire        i_link_valid,
   input  wire  [7:0] i_link_data,
   input  wire        i_link_last,
   input  wire  [1:0] i_link_class,
   input  wire        i_rx_ready,
   output logic       o_link_ready,
   output logic       o_rx_valid,
   output logic [7:0] o_rx_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [7:0] rep[$];
   initial begin
      o_link_ready = 1'b0;
      o_rx_valid = 1'b0;
      o_rx_data = 8'h00;
   end
   always @(posedge i_clk) begin
      if (i_link_valid && o_link_ready) begin
         got.push_back(i_link_data);
         if (i_link_last && i_link_class == 2'h2)
            for (int k = 0; k < i_nrep; k++) rep.push_back(8'h10 + 8'(k));
         else if (i_link_last)
            rep.push_back(8'h00);
      end
      if (o_rx_valid && i_rx_ready)
         void'(rep.pop_front());
      #1;
      o_link_ready = !i_stall;
      o_rx_valid = rep.size() > 0;
      // idle line flips so a stale byte is never mistaken for data
      o_rx_data = o_rx_valid ? rep[0] : ~o_rx_data;
   end
endmodule // scf_slave_model

// ==== verif/scf_top_sva.sv ====
/* checker of the forwarder's top ports: flags, interrupt, polling, stream hold.
   assumes one clock domain and the synchronous active-low reset. */
module scf_top_chk (
   input wire       i_clk,
   input wire       i_rst_b,
   input wire       i_completion_signal_select,
   input wire       i_poll_stop,
   input wire       i_link_ready,
   input wire       o_link_valid,
   input wire [7:0] o_link_data,
   input wire       o_int_b,
   input wire       o_output_full_flag,
   input wire       o_input_data_flag,
   input wire       o_run_end_interrupt,
   input wire       o_polling_active,
   input wire       o_done_ready,
   input wire       o_rx_ready,
   input wire       o_reply_valid,
   input wire       o_host_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   sequence s_stall;
      o_link_valid && !i_link_ready;
   endsequence
   property p_int;
      o_int_b == !(o_output_full_flag || o_input_data_flag || o_run_end_interrupt);
   endproperty
   a_int: assert property (p_int) else $error("interrupt not tied to flags");
   property p_excl;
      !(o_output_full_flag && o_input_data_flag);
   endproperty
   a_excl: assert property (p_excl) else $error("two reply flags at once");
   property p_rst;
      $rose(i_rst_b) |-> o_int_b && !o_polling_active;
   endproperty
   a_rst: assert property (p_rst) else $error("state after reset");
   property p_stop;
      i_poll_stop |=> !o_polling_active;
   endproperty
   a_stop: assert property (p_stop) else $error("polling survived stop");
   property p_done;
      o_done_ready |-> o_polling_active;
   endproperty
   a_done: assert property (p_done) else $error("run end taken without polling");
   property p_hold;
      s_stall |=> o_link_valid && $stable(o_link_data);
   endproperty
   a_hold: assert property (p_hold) else $error("link byte changed while stalled");
   property p_read;
      o_reply_valid |-> !o_host_ready && !o_rx_ready;
   endproperty
   a_read: assert property (p_read) else $error("writes open during reply");
   property p_flag;
      (o_output_full_flag || o_input_data_flag) |-> o_reply_valid;
   endproperty
   a_flag: assert property (p_flag) else $error("flag without pending reply");
   property p_sel;
      $rose(o_run_end_interrupt) |-> $past(i_completion_signal_select);
   endproperty
   a_sel: assert property (p_sel) else $error("run end raised while deselected");
endmodule // scf_top_chk
bind scf_top scf_top_chk u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
   .i_completion_signal_select(i_completion_signal_select), .i_poll_stop(i_poll_stop),
   .i_link_ready(i_link_ready), .o_link_valid(o_link_valid), .o_link_data(o_link_data),
   .o_int_b(o_int_b), .o_output_full_flag(o_output_full_flag),
   .o_input_data_flag(o_input_data_flag), .o_run_end_interrupt(o_run_end_interrupt),
   .o_polling_active(o_polling_active), .o_done_ready(o_done_ready),
   .o_rx_ready(o_rx_ready), .o_reply_valid(o_reply_valid), .o_host_ready(o_host_ready));

// ==== verif/tb_slave_command_forwarder.sv ====
/* bench of the forwarder: host command/data writes, reply reads, run ends.
   assumes the slave link model in place of the slaves. */
module tb_slave_command_forwarder;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_rst_b, i_cmd_we, i_data_we, i_data_re, sel, stop, lrdy, rxv, rxr;
   logic dv, drdy, stall, lv, last, rv, ofull, idat, rend, int_b, poll, hrdy;
   logic [7:0] wd, rdata, ld, rxd, dst;
   wire  [7:0] stf;
   logic [3:0] da, la, nrep;
   logic [1:0] lc;
   int fails = 0, cmp_count = 0, cyc = 0;
   logic [7:0] q[$];
   scf_top u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cmd_we(i_cmd_we),
      .i_data_we(i_data_we), .i_wdata(wd), .i_data_re(i_data_re), .o_rdata(rdata),
      .o_host_ready(hrdy), .o_reply_valid(rv), .o_output_full_flag(ofull),
      .o_input_data_flag(idat), .o_run_end_interrupt(rend), .o_int_b(int_b),
      .i_completion_signal_select(sel), .i_poll_stop(stop), .o_polling_active(poll),
      .o_link_valid(lv), .i_link_ready(lrdy), .o_link_data(ld), .o_link_last(last),
      .o_link_addr(la), .o_link_class(lc), .i_rx_valid(rxv), .i_rx_data(rxd),
      .o_rx_ready(rxr), .i_done_valid(dv), .i_done_addr(da), .i_done_status(dst),
      .o_done_ready(drdy), .o_alarm_stop_flag(stf[7]), .o_cw_limit_stop_flag(stf[6]),
      .o_ccw_limit_stop_flag(stf[5]), .o_cw_fast_limit_flag(stf[4]),
      .o_ccw_fast_limit_flag(stf[3]), .o_origin_stop_flag(stf[2]),
      .o_stop_command_flag(stf[1]), .o_normal_end_flag(stf[0]));
   scf_slave_model u_slv (.i_clk(i_clk), .i_stall(stall), .i_nrep(nrep), .i_link_valid(lv),
      .i_link_data(ld), .i_link_last(last), .i_link_class(lc), .i_rx_ready(rxr),
      .o_link_ready(lrdy), .o_rx_valid(rxv), .o_rx_data(rxd));
   initial begin
      i_clk = 0;
      forever #2.5 i_clk = ~i_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // strobes stay up between bytes; send lowers them once at the end
   task automatic wr(input logic c, input logic [7:0] b);
      i_cmd_we = c;
      i_data_we = !c;
      wd = b;
      do @(negedge i_clk); while (!c && hrdy !== 1'b1);
      @(posedge i_clk);
      #1;
   endtask
   task automatic send(input logic [7:0] c, input logic [7:0] d[$]);
      wr(1'b1, c);
      foreach (d[k]) wr(1'b0, d[k]);
      i_cmd_we = 0;
      i_data_we = 0;
   endtask
   // f = {output flag, input flag, run end, int_b}
   task automatic reply(input logic [7:0] e[$], input logic [3:0] f);
      // look after the edge settles, never in the step that moves the state
      while (rv !== 1'b1) begin
         @(posedge i_clk);
         #1;
      end
      @(posedge i_clk);
      #1;
      chk({4'h0, ofull, idat, rend, int_b}, {4'h0, f});
      foreach (e[k]) begin
         chk(rdata, e[k]);
         i_data_re = 1;
         @(posedge i_clk);
         #1;
         i_data_re = 0;
         @(posedge i_clk);
         #1;
      end
      chk({4'h0, ofull, idat, rend, int_b}, 8'h01);
   endtask
   task automatic fwd(input logic [7:0] e[$]);
      chk(8'(u_slv.got.size()), 8'(e.size()));
      foreach (e[k]) chk(u_slv.got[k], e[k]);
      u_slv.got.delete();
   endtask
   task automatic done(input logic [7:0] s);
      dv = 1;
      da = 4'h3;
      dst = s;
      do @(negedge i_clk); while (drdy !== 1'b1);
      @(posedge i_clk);
      #1;
      dv = 0;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc > 5000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      {i_rst_b, i_cmd_we, i_data_we, i_data_re, stop, dv, stall} = 0;
      {wd, dst, da} = 0;
      sel = 1;
      nrep = 4'h3;
      repeat (3) @(posedge i_clk);
      #1;
      i_rst_b = 1;
      send(8'h03, '{8'h02, 8'hA5, 8'h5A});
      chk({4'h0, la}, 8'h03);
      chk({6'h0, lc}, 8'h00);
      reply('{8'h03, 8'h00}, 4'h8);
      fwd('{8'hA5, 8'h5A});
      chk({7'h0, poll}, 8'h01);
      done(8'h81);
      reply('{8'h03, 8'h81}, 4'h2);
      chk(stf, 8'h81);
      sel = 0;
      done(8'h40);
      reply('{8'h03, 8'h40}, 4'h1);
      chk(stf, 8'h40);
      stop = 1;
      @(posedge i_clk);
      #1;
      stop = 0;
      chk({7'h0, poll}, 8'h00);
      // stalled link: the fifo must fill and push back on the host
      stall = 1;
      q = '{8'h11};
      for (int k = 1; k <= 17; k++) q.push_back(8'(k));
      fork
         send(8'h15, q);
         begin
            repeat (30) @(negedge i_clk);
            chk({7'h0, hrdy}, 8'h00);
            stall = 0;
         end
      join
      chk({6'h0, lc}, 8'h01);
      reply('{8'h05, 8'h00}, 4'h8);
      chk({6'h0, poll, drdy}, 8'h00);
      q.delete(0);
      fwd(q);
      send(8'h27, '{8'h03, 8'hC3});
      chk({6'h0, lc}, 8'h02);
      reply('{8'h07, 8'h10, 8'h11, 8'h12}, 4'h4);
      fwd('{8'hC3});
      // zero reply count: address-only reply, the slave sends nothing back
      nrep = 4'h0;
      send(8'h27, '{8'h00, 8'hC3});
      reply('{8'h07}, 4'h4);
      fwd('{8'hC3});
      wrap_up();
   end
endmodule // tb_slave_command_forwarder
